// ===== src/tso_stream_output.sv
// Purpose : Transport-stream output stage: byte clock, framing and error flags.
// Assumes : Packet bytes arrive with a first-byte mark and an uncorrectable mark.
// Notes   : The symbol-rate and decimation periods come from upstream rate logic.
//
// Contract
// - Two control bits pick the byte clock source
// - Symbol mode clock runs only after symbol lock
// - Test mode derives clock from decimation ratio
// - Divider mode period is setting plus six
// - External clock edge choice follows polarity bit
// - Polarity one launches outputs on falling edge
// - Packet bytes consecutive unless the buffer runs dry mid-packet (last byte held), data low in gaps
// - Start flag marks only the first byte
// - Valid spans first through last byte
// - Uncorrectable DVB packets get header error bit forced
// - Latched error mode: low until good packets
// - Invert bit flips the block error pin
// - Polarity bit selects normal or inverted clock pin for internal sources
// - Serial bit sends data on lane zero
// - Aligner locks after field plus two syncs
// - Byte period truncated integer of PLL clocks
// - Sync byte position jitter within one period
`default_nettype none

module tso_stream_output
  import tso_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clock_enable,
  input  wire logic [7:0] reg_address,
  input  wire logic [7:0] reg_write_data,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_read_data,
  input  wire logic       stream_valid,
  output logic            stream_ready,
  input  wire logic [7:0] stream_data,
  input  wire logic       stream_first,
  input  wire logic       stream_uncorrectable,
  input  wire logic       packet_format_alt,
  input  wire logic       symbol_lock,
  input  wire logic [7:0] symbol_period_n,
  input  wire logic [7:0] decimation_period,
  input  wire logic       descrambler_lock,
  input  wire logic       sync_word_seen,
  input  wire logic       sync_word_good,
  input  wire logic       external_clock_in,
  output logic            byte_clock_out,
  output logic      [7:0] packet_data_out,
  output logic            packet_start_flag,
  output logic            packet_valid_flag,
  output logic            block_error_flag,
  output logic            aligner_locked
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    out_ctrl;
    logic [7:0]    fec_ctrl;
    logic [7:0]    monitor_control;
    logic [7:0]    div_ctrl;
    logic [7:0]    rdata;
    logic [8:0]    phase;
    logic          bclk;
    tso_state_type state;
    logic [7:0]    byte_cnt;
    logic [2:0]    bit_idx;
    logic [7:0]    shreg;
    logic          bad;
    logic [7:0]    dout;
    logic          start;
    logic          valid;
    logic          err_ok;
    logic [3:0]    al_cnt;
    logic          al_lock;
  } tso_core_type;

  localparam tso_core_type TSO_CORE_RST = '{
    out_ctrl: TSO_RST_OUT_CTRL,
    fec_ctrl: TSO_RST_FEC_CTRL,
    monitor_control: TSO_RST_MONITOR_CONTROL,
    div_ctrl: TSO_RST_DIV_CTRL,
    state:    TSO_IDLE,
    err_ok:   1'b1,
    default:  '0
  };

  tso_core_type             st;
  tso_core_type             nxt;
  tso_source_type           src;
  logic [8:0]               period;
  logic [8:0]               half;
  logic                     launch;
  logic                     serial;
  logic                     pol;
  logic                     mode_high;
  logic [7:0]               plen;
  logic                     need_byte;
  logic                     buf_valid;
  logic                     buf_pop;
  logic [TSO_WORD_W-1:0]    buf_word;
  logic [7:0]               lane_byte;
  logic [3:0]               al_target;

  // ----------------------------------------------------------------------
  // Two-entry buffer in the data path
  // ----------------------------------------------------------------------
  // A receiver stall (no launch) simply leaves words here; the source sees
  // stream_ready fall instead of losing a word.
  tso_pair_buffer #(
    .WIDTH (TSO_WORD_W),
    .DEPTH (TSO_BUF_DEPTH)
  ) u_buffer (
    .clock        (clock),
    .reset        (reset),
    .clock_enable (clock_enable),
    .in_valid     (stream_valid),
    .in_ready     (stream_ready),
    .in_data      ({stream_uncorrectable, stream_first, stream_data}),
    .out_valid    (buf_valid),
    .out_ready    (buf_pop),
    .out_data     (buf_word)
  );

  // Decoded control fields
  assign src       = tso_source_type'({st.out_ctrl[TSO_BIT_MANUAL],
                                       st.fec_ctrl[TSO_BIT_SR_DIS]});
  assign serial    = st.out_ctrl[TSO_BIT_SERIAL];
  assign pol       = st.out_ctrl[TSO_BIT_POLARITY];
  assign mode_high = st.monitor_control[TSO_BIT_ERR_MODE];
  assign plen      = packet_format_alt ? TSO_LEN_ALT : TSO_LEN_DVB;
  assign need_byte = !serial || (st.bit_idx == '0);
  assign al_target = {1'b0, st.out_ctrl[TSO_AL_MSB:0]} + TSO_AL_OFFSET;

  // ----------------------------------------------------------------------
  // Byte clock period per source
  // ----------------------------------------------------------------------
  // Upstream supplies the truncated period in sampling clocks; a period
  // below two cannot form a clock and is lifted to two.
  always_comb begin
    case (src)
      TSO_SRC_SYMBOL: period = {1'b0, symbol_period_n};
      TSO_SRC_DECIM:  period = {1'b0, decimation_period};
      TSO_SRC_DIVIDE: period = {1'b0, st.div_ctrl} + TSO_DIV_OFFSET;
      default:        period = TSO_MIN_PERIOD;
    endcase
    if (period < TSO_MIN_PERIOD) begin
      period = TSO_MIN_PERIOD;
    end
    half = period >> 1;
  end

  // ----------------------------------------------------------------------
  // Next state: registers, clock generation, packet engine, aligner
  // ----------------------------------------------------------------------
  always_comb begin
    nxt       = st;
    launch    = 1'b0;
    buf_pop   = 1'b0;
    lane_byte = buf_word[7:0];

    // Register writes; reserved monitor bits store nothing
    if (reg_write) begin
      case (reg_address)
        TSO_ADDR_OUT_CTRL: nxt.out_ctrl = reg_write_data;
        TSO_ADDR_FEC_CTRL: nxt.fec_ctrl = reg_write_data;
        TSO_ADDR_MONITOR_CONTROL: nxt.monitor_control = reg_write_data & TSO_MON_MASK;
        TSO_ADDR_DIV_CTRL: nxt.div_ctrl = reg_write_data;
        default:           nxt.out_ctrl = st.out_ctrl;
      endcase
    end

    // Register reads; unmapped addresses answer zero
    if (reg_read) begin
      case (reg_address)
        TSO_ADDR_OUT_CTRL: nxt.rdata = st.out_ctrl;
        TSO_ADDR_FEC_CTRL: nxt.rdata = st.fec_ctrl;
        TSO_ADDR_MONITOR_CONTROL: nxt.rdata = st.monitor_control;
        TSO_ADDR_DIV_CTRL: nxt.rdata = st.div_ctrl;
        default:           nxt.rdata = TSO_READ_NONE;
      endcase
    end

    // Byte clock; every launch falls on the internal clock's falling edge,
    // except with the external clock where polarity picks the edge
    if (src == TSO_SRC_EXTERNAL) begin
      nxt.phase = '0;
      nxt.bclk  = external_clock_in;
      launch    = pol ? (st.bclk & ~external_clock_in)
                      : (~st.bclk & external_clock_in);
    end else if ((src == TSO_SRC_SYMBOL) && !symbol_lock) begin
      nxt.phase = '0;
      nxt.bclk  = 1'b0;
    end else begin
      nxt.phase = (st.phase >= period - 9'h001) ? '0 : st.phase + 9'h001;
      nxt.bclk  = (nxt.phase < half);
      launch    = st.bclk & ~nxt.bclk;
    end

    // Packet engine, advanced once per launch
    if (launch) begin
      nxt.start = 1'b0;
      if ((st.state == TSO_SEND) && !need_byte) begin
        nxt.dout    = {7'h00, st.shreg[7]};
        nxt.shreg   = {st.shreg[6:0], 1'b0};
        nxt.bit_idx = st.bit_idx + 3'h1;
      end else if ((st.state == TSO_SEND) && (st.byte_cnt != plen)) begin
        // An empty buffer mid-packet holds the lane rather than inventing data
        if (buf_valid) begin
          buf_pop = 1'b1;
          if ((st.byte_cnt == TSO_ERR_INDEX) && st.bad && !packet_format_alt &&
              st.out_ctrl[TSO_BIT_AUTO_ERR]) begin
            lane_byte[TSO_ERR_BIT] = 1'b1;
          end
          nxt.dout     = serial ? {7'h00, lane_byte[7]} : lane_byte;
          nxt.shreg    = {lane_byte[6:0], 1'b0};
          nxt.bit_idx  = serial ? TSO_FIRST_BIT : 3'h0;
          nxt.byte_cnt = st.byte_cnt + 8'h01;
        end
      end else begin
        // Gap, or the launch after the last byte
        nxt.state   = TSO_IDLE;
        nxt.dout    = 8'h00;
        nxt.valid   = 1'b0;
        nxt.bit_idx = 3'h0;
        if ((st.state == TSO_SEND) && !mode_high) begin
          nxt.err_ok = 1'b1;
        end
        if (buf_valid) begin
          // Stray bytes before a first-byte mark are dropped to resync
          buf_pop = 1'b1;
          if (buf_word[8]) begin
            nxt.state    = TSO_SEND;
            nxt.start    = 1'b1;
            nxt.valid    = 1'b1;
            nxt.bad      = buf_word[9];
            nxt.err_ok   = !buf_word[9];
            nxt.dout     = serial ? {7'h00, lane_byte[7]} : lane_byte;
            nxt.shreg    = {lane_byte[6:0], 1'b0};
            nxt.bit_idx  = serial ? TSO_FIRST_BIT : 3'h0;
            nxt.byte_cnt = 8'h01;
          end
        end
      end
    end

    // Lost descrambler lock pulls the latched flag low at once
    if (mode_high && !descrambler_lock) begin
      nxt.err_ok = 1'b0;
    end

    // Byte aligner: consecutive good sync words up to field plus two
    if (sync_word_seen) begin
      if (!sync_word_good) begin
        nxt.al_cnt  = '0;
        nxt.al_lock = 1'b0;
      end else if (!st.al_lock) begin
        nxt.al_cnt = st.al_cnt + 4'h1;
        if (st.al_cnt + 4'h1 == al_target) begin
          nxt.al_lock = 1'b1;
        end
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= TSO_CORE_RST;
    end else if (clock_enable) begin
      st <= nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The external clock is passed through as it arrives; internal sources
  // follow the polarity bit so launch stays on the pin's chosen edge
  assign byte_clock_out    = (src == TSO_SRC_EXTERNAL) ? st.bclk
                           : (pol ? st.bclk : ~st.bclk);
  assign packet_data_out   = st.dout;
  assign packet_start_flag = st.start;
  assign packet_valid_flag = st.valid;
  assign block_error_flag  = st.err_ok ^ st.out_ctrl[TSO_BIT_INVERT];
  assign aligner_locked    = st.al_lock;
  assign reg_read_data     = st.rdata;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [10:0] chk_launches;
  logic [8:0]  chk_cycles;
  logic        chk_seen;
  logic        chk_rise;
  logic [10:0] chk_expect;

  assign chk_rise   = clock_enable && !st.bclk && nxt.bclk;
  assign chk_expect = serial ? ({3'h0, plen} << TSO_SER_SHIFT) : {3'h0, plen};

  // Launches inside a packet and cycles between clock rises
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      chk_launches <= '0;
      chk_cycles   <= '0;
      chk_seen     <= 1'b0;
    end else if (clock_enable) begin
      if (launch && buf_pop && buf_word[8] && nxt.start) begin
        chk_launches <= 11'h001;
      end else if (launch && st.valid) begin
        chk_launches <= chk_launches + 11'h001;
      end
      chk_cycles <= chk_rise ? 9'h001 : chk_cycles + 9'h001;
      if (reg_write || src != TSO_SRC_DIVIDE) begin
        chk_seen <= 1'b0;
      end else if (chk_rise) begin
        chk_seen <= 1'b1;
      end
    end
  end

  sequence packet_end_s;
    $fell(st.valid);
  endsequence
  sequence bad_packet_start_s;
    $rose(st.start) && st.bad;
  endsequence

  start_has_valid_a: assert property (@(posedge clock) disable iff (reset)
    st.start |-> st.valid)
    else $error("start flag without valid");
  gap_data_low_a: assert property (@(posedge clock) disable iff (reset)
    !st.valid |-> (st.dout == 8'h00))
    else $error("data not low between packets");
  packet_length_a: assert property (@(posedge clock) disable iff (reset)
    packet_end_s |-> ($past(chk_launches) == chk_expect))
    else $error("packet length wrong");
  bad_packet_flag_a: assert property (@(posedge clock) disable iff (reset)
    bad_packet_start_s |-> (block_error_flag == st.out_ctrl[TSO_BIT_INVERT]))
    else $error("error flag not active on bad packet");
  lock_loss_a: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && mode_high && !descrambler_lock && !reg_write)
      |=> (block_error_flag == st.out_ctrl[TSO_BIT_INVERT]))
    else $error("error flag not active without descrambler lock");
  launch_edge_a: assert property (@(posedge clock) disable iff (reset)
    (src != TSO_SRC_EXTERNAL && pol && $changed(st.valid)) |-> $fell(byte_clock_out))
    else $error("outputs changed off the falling clock edge");
  divider_period_a: assert property (@(posedge clock) disable iff (reset)
    (chk_rise && chk_seen && !reg_write) |-> (chk_cycles == period))
    else $error("divider period wrong");
  control_reset_a: assert property (@(posedge clock)
    $fell(reset) |-> (st.out_ctrl == TSO_RST_OUT_CTRL))
    else $error("output control reset value wrong");
  aligner_lock_a: assert property (@(posedge clock) disable iff (reset)
    $rose(st.al_lock) |-> (st.al_cnt == al_target))
    else $error("aligner locked after wrong count");
  symbol_gate_a: assert property (@(posedge clock) disable iff (reset)
    (src == TSO_SRC_SYMBOL && !symbol_lock) |-> !launch)
    else $error("byte clock ran without symbol lock");

endmodule : tso_stream_output

`default_nettype wire

// ===== include/tso_pkg.sv
// Purpose : Shared constants and types of the transport-stream output stage.
// Assumes : One 40 MHz sampling clock drives the whole block.
// Notes   : Register offsets are byte addresses of the 8-bit control port.
`default_nettype none

package tso_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] TSO_ADDR_OUT_CTRL = 8'h60;
  localparam logic [7:0] TSO_ADDR_FEC_CTRL = 8'h61;
  localparam logic [7:0] TSO_ADDR_MONITOR_CONTROL = 8'h67;
  localparam logic [7:0] TSO_ADDR_DIV_CTRL = 8'h21;

  localparam logic [7:0] TSO_RST_OUT_CTRL  = 8'h33;
  localparam logic [7:0] TSO_RST_FEC_CTRL  = 8'h00;
  localparam logic [7:0] TSO_RST_MONITOR_CONTROL  = 8'h00;
  localparam logic [7:0] TSO_RST_DIV_CTRL  = 8'h00;
  localparam logic [7:0] TSO_READ_NONE     = 8'h00;

  // Field positions
  localparam int TSO_BIT_MANUAL   = 7;
  localparam int TSO_BIT_INVERT   = 6;
  localparam int TSO_BIT_POLARITY = 5;
  localparam int TSO_BIT_AUTO_ERR = 4;
  localparam int TSO_BIT_SERIAL   = 3;
  localparam int TSO_AL_MSB       = 2;
  localparam int TSO_BIT_SR_DIS   = 7;
  localparam int TSO_BIT_ERR_MODE = 7;
  localparam int TSO_SEL_MSB      = 3;
  localparam logic [7:0] TSO_MON_MASK = 8'h8F;

  // ----------------------------------------------------------------------
  // Packet and timing constants
  // ----------------------------------------------------------------------
  localparam logic [7:0]  TSO_LEN_DVB    = 8'hBC;
  localparam logic [7:0]  TSO_LEN_ALT    = 8'h82;
  localparam logic [7:0]  TSO_ERR_INDEX  = 8'h01;
  localparam int          TSO_ERR_BIT    = 7;
  localparam logic [8:0]  TSO_DIV_OFFSET = 9'h006;
  localparam logic [8:0]  TSO_MIN_PERIOD = 9'h002;
  localparam logic [3:0]  TSO_AL_OFFSET  = 4'h2;
  localparam logic [2:0]  TSO_FIRST_BIT  = 3'h1;
  localparam int          TSO_SER_SHIFT  = 3;
  localparam int          TSO_CLOCK_HZ   = 40_000_000;
  localparam int          TSO_BUF_DEPTH  = 2;
  localparam int          TSO_WORD_W     = 10;

  // Byte clock source, coded as {manual bit, symbol-rate disable bit}
  typedef enum logic [1:0] {
    TSO_SRC_SYMBOL   = 2'b00,
    TSO_SRC_DECIM    = 2'b01,
    TSO_SRC_DIVIDE   = 2'b10,
    TSO_SRC_EXTERNAL = 2'b11
  } tso_source_type;

  typedef enum logic [0:0] {
    TSO_IDLE = 1'b0,
    TSO_SEND = 1'b1
  } tso_state_type;

endpackage : tso_pkg

`default_nettype wire

// ===== src/tso_pair_buffer.sv
// Purpose : Small valid/ready FIFO between the packet source and the output engine.
// Assumes : Depth is one or more; the source honours in_ready.
// Notes   : Full and empty come straight from the occupancy count.
`default_nettype none

module tso_pair_buffer #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             clock_enable,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 count;
  } tso_buf_type;

  tso_buf_type st;
  tso_buf_type nxt;
  logic        push;
  logic        pop;

  // ----------------------------------------------------------------------
  // Handshake and next state
  // ----------------------------------------------------------------------
  assign in_ready  = (st.count != (PW+1)'(DEPTH)); // Honest full stalls the source
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap explicitly so a non-power-of-two depth stays correct
  always_comb begin
    nxt = st;
    if (push) begin
      nxt.mem[st.wp] = in_data;
      nxt.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + PW'(1);
    end
    if (pop) begin
      nxt.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + PW'(1);
    end
    if (push && !pop) begin
      nxt.count = st.count + (PW+1)'(1);
    end else if (pop && !push) begin
      nxt.count = st.count - (PW+1)'(1);
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else if (clock_enable) begin
      st <= nxt;
    end
  end

endmodule : tso_pair_buffer

`default_nettype wire

// ===== bench/tso_stream_receiver.sv
// Purpose : Downstream receiver model that samples the output link.
// Assumes : Polarity bit is 1, so the rising byte clock edge is the sample point.
// Notes   : Passive; records bytes, starts, low error flags and the byte period.
`default_nettype none

module tso_stream_receiver (
  input wire logic       clock,
  input wire logic       byte_clock_out,
  input wire logic [7:0] packet_data_out,
  input wire logic       packet_start_flag,
  input wire logic       packet_valid_flag,
  input wire logic       block_error_flag
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] got_bytes[$];
  int         starts  = 0;
  int         err_low = 0;
  int         period  = 0;
  int         count   = 0;
  logic       bclk_q  = 1'b0;

  // Period in sampling clocks; on the falling edge to stay clear of launch updates
  always @(negedge clock) begin
    if (byte_clock_out && !bclk_q) period = count;
    count = (byte_clock_out && !bclk_q) ? 1 : count + 1;
    bclk_q = byte_clock_out;
  end

  // Take a byte only while valid, as a real decoder would
  always @(posedge byte_clock_out) begin
    if (packet_valid_flag === 1'b1) begin
      got_bytes.push_back(packet_data_out);
      starts  += (packet_start_flag === 1'b1);
      err_low += (block_error_flag === 1'b0);
    end
  end
endmodule : tso_stream_receiver

`default_nettype wire

// ===== bench/tb.sv
// Purpose : Self-checking bench of the transport-stream output stage.
// Assumes : Divider source with divisor six; DVB format; one clock domain.
// Notes   : Error flag mode low, so the flag should follow one bad packet only.
`default_nettype none

module tb
  import tso_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_address = 8'h00, reg_write_data = 8'h00, stream_data = 8'h00;
  logic       stream_valid = 1'b0, stream_first = 1'b0, stream_uncorrectable = 1'b0;
  logic       sync_word_seen = 1'b0, sync_word_good = 1'b0;
  logic       symbol_lock = 1'b1, descrambler_lock = 1'b1, external_clock_in = 1'b0;
  logic [7:0] reg_read_data, packet_data_out;
  logic       stream_ready, byte_clock_out, packet_start_flag, packet_valid_flag;
  logic       block_error_flag, aligner_locked;
  int         n_errors = 0, tests_run = 0;

  tso_stream_output i_dut (.clock(clock), .reset(reset), .clock_enable(1'b1),
    .reg_address(reg_address), .reg_write_data(reg_write_data), .reg_write(reg_write),
    .reg_read(reg_read), .reg_read_data(reg_read_data), .stream_valid(stream_valid),
    .stream_ready(stream_ready), .stream_data(stream_data), .stream_first(stream_first),
    .stream_uncorrectable(stream_uncorrectable), .packet_format_alt(1'b0),
    .symbol_lock(symbol_lock), .symbol_period_n(8'h08), .decimation_period(8'h0A),
    .descrambler_lock(descrambler_lock), .sync_word_seen(sync_word_seen),
    .sync_word_good(sync_word_good), .external_clock_in(external_clock_in),
    .byte_clock_out(byte_clock_out), .packet_data_out(packet_data_out),
    .packet_start_flag(packet_start_flag), .packet_valid_flag(packet_valid_flag),
    .block_error_flag(block_error_flag), .aligner_locked(aligner_locked));

  tso_stream_receiver i_rx (.clock(clock), .byte_clock_out(byte_clock_out),
    .packet_data_out(packet_data_out), .packet_start_flag(packet_start_flag),
    .packet_valid_flag(packet_valid_flag), .block_error_flag(block_error_flag));

  // 40 MHz sampling clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  // Free-running external byte clock of eight sampling clocks, below the limit
  initial begin
    forever begin
      repeat (4) @(posedge clock);
      external_clock_in <= ~external_clock_in;
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_address <= a;
    reg_write_data <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Read data is registered, so it is looked at one edge after the request
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_address <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk(reg_read_data, exp);
  endtask : rd

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic reset_values();
    rd(TSO_ADDR_OUT_CTRL, 8'h33);
    rd(TSO_ADDR_MONITOR_CONTROL, 8'h00);
    rd(8'hFE, TSO_READ_NONE);
  endtask : reset_values

  // Lock needs field plus two good syncs; a bad one starts the count over
  task automatic aligner_count();
    for (int i = 1; i <= 6; i++) begin
      @(posedge clock);
      sync_word_seen <= 1'b1;
      sync_word_good <= (i != 1);
      @(posedge clock);
      sync_word_seen <= 1'b0;
      @(negedge clock);
      chk({7'h00, aligner_locked}, {7'h00, i == 6});
    end
  endtask : aligner_count

  // One uncorrectable DVB packet through the divider clock, stalled by a full buffer
  task automatic bad_packet();
    logic ok;
    int   g;
    wr(TSO_ADDR_DIV_CTRL, 8'h00);
    wr(TSO_ADDR_OUT_CTRL, 8'hB3);
    for (int i = 0; i < int'(TSO_LEN_DVB); i++) begin
      stream_valid <= 1'b1;
      stream_first <= (i == 0);
      stream_uncorrectable <= 1'b1;
      stream_data <= (i == 0) ? 8'h47 : 8'(i);
      g = 0;
      do begin
        @(negedge clock);
        ok = stream_ready;
        @(posedge clock);
        g++;
      end while (!ok && g < 100);
      if (!ok) begin
        n_errors++;
        report_and_stop();
      end
    end
    stream_valid <= 1'b0;
    for (g = 0; g < 3000 && (packet_valid_flag !== 1'b0 || i_rx.got_bytes.size() < 188);
         g++) @(negedge clock);
    if (g >= 3000) begin
      n_errors++;
      report_and_stop();
    end
    chk(8'(i_rx.got_bytes.size()), TSO_LEN_DVB);
    chk(8'(i_rx.starts), 8'h01);
    chk(8'(i_rx.err_low), TSO_LEN_DVB);
    chk(8'(i_rx.period), 8'h06);
    for (int i = 0; i < i_rx.got_bytes.size(); i++)
      chk(i_rx.got_bytes[i], (i == 0) ? 8'h47 : (i == 1) ? 8'h81 : 8'(i));
    repeat (12) @(negedge clock);
    chk({packet_data_out[7:1], packet_valid_flag}, 8'h00);
    chk({7'h00, block_error_flag}, 8'h01);
    wr(TSO_ADDR_OUT_CTRL, 8'hF3);
    rd(TSO_ADDR_OUT_CTRL, 8'hF3);
    chk({7'h00, block_error_flag}, 8'h00);
  endtask : bad_packet

  // Other clock sources and the latched error mode, with no packet in flight
  task automatic sources_and_lock();
    wr(TSO_ADDR_FEC_CTRL, 8'h80);
    repeat (40) @(posedge clock);
    chk(8'(i_rx.period), 8'h08);
    wr(TSO_ADDR_OUT_CTRL, 8'h33);
    repeat (40) @(posedge clock);
    chk(8'(i_rx.period), 8'h0A);
    wr(TSO_ADDR_MONITOR_CONTROL, 8'h80);
    descrambler_lock <= 1'b0;
    repeat (2) @(negedge clock);
    chk({7'h00, block_error_flag}, 8'h00);
    @(posedge clock);
    descrambler_lock <= 1'b1;
    repeat (20) @(negedge clock);
    chk({7'h00, block_error_flag}, 8'h00);
    wr(TSO_ADDR_FEC_CTRL, 8'h00);
    symbol_lock <= 1'b0;
    repeat (2) @(posedge clock);
    repeat (16) begin
      @(negedge clock);
      chk({7'h00, byte_clock_out}, 8'h00);
    end
  endtask : sources_and_lock

  // Reset for four cycles, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    reset_values();
    aligner_count();
    bad_packet();
    sources_and_lock();
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
